// ### common/rcgu_defines.vh
// Constants of the reset and clock gating unit
`ifndef RCGU_DEFINES_VH
`define RCGU_DEFINES_VH

// Register addresses (7-bit register index)
`define RCGU_ADDR_GENCONF 7'h00
`define RCGU_ADDR_EVENT_FLAG_REGISTER 7'h0e
`define RCGU_ADDR_GATE_DELAY 7'h14
`define RCGU_ADDR_GATE_CTRL 7'h4f
`define RCGU_ADDR_STATUS 7'h4e

// Field positions
`define RCGU_GENCONF_GATE_EN_BIT 17
`define RCGU_EVENT_FLAG_REGISTER_RESET_BIT 31
`define RCGU_TRIG_MSB 2
`define RCGU_TRIG_LSB 0
`define RCGU_KEY_MSB 31
`define RCGU_KEY_LSB 8

// Key and trigger values
`define RCGU_SOFT_RESET_KEY 24'h525354
`define RCGU_TRIGGER_ARM 3'h7

// Reset values
`define RCGU_GENCONF_RESET 32'h00006020
`define RCGU_GATE_DELAY_RESET 32'h00000000
`define RCGU_TRIGGER_RESET 3'h0
`define RCGU_EVENT_FLAG_REGISTER_RESET 32'h80000000

// Synchroniser depth for pin inputs
`define RCGU_SYNC_STAGES 2

`endif

// ### design/rcgu_sync.v
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`include "rcgu_defines.vh"

module rcgu_sync
#(
   parameter WIDTH = 1
)
(
   // Clock and reset
   input wire clk_sys,
   input wire reset_n,
   // Asynchronous inputs and synchronised outputs
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   genvar i;

   // One two-stage chain per bit; first stage feeds only the second
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         reg meta_r;
         reg stable_r;
         always @(posedge clk_sys or negedge reset_n)
         begin
            if (!reset_n)
            begin
               meta_r <= 1'b0;
               stable_r <= 1'b0;
            end
            else
            begin
               meta_r <= async_in[i];
               stable_r <= meta_r;
            end
         end
         assign sync_out[i] = stable_r;
      end
   endgenerate

endmodule // rcgu_sync

// ### design/rcgu_top.v
// Reset combination, software reset and clock gating control
//
// Summary of operation
// - Hardware reset pin low returns every register to its default.
// - Power-on reset input resets all registers without host action.
// - Key 0x525354 written to bits 31:8 of 0x4F resets all registers.
// - Software reset ignored while freeze_condition is high.
// - Any reset source sets the reset-occurred flag, event register bit 31.
// - Gating trigger acts only when gating enable bit 17 of 0x00 is set.
// - Writing 0x7 to trigger field bits 2:0 of 0x4F arms gating.
// - Trigger loads delay register into counter; gate when it reaches zero.
// - Zero delay gates the clock right after the trigger write.
// - Wake pin high ends gating and restores the internal clock.
// - Operating clock is the external clock pin; gating acts on its copy.
`timescale 1ns/1ps
`include "rcgu_defines.vh"

module rcgu_top
(
   // External clock pin and hardware reset pin
   input wire clk_sys,
   input wire reset_n,
   // Power-on reset from the supply monitor
   input wire power_on_reset_n,
   // Wake-up pin, active high, asynchronous
   input wire wake_input_pin,
   // Freeze condition from safety logic, same clock
   input wire freeze_condition,
   // Register port
   input wire [6:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   output reg reg_rvalid,
   // Clock gating and reset outputs
   output reg core_clock_enable,
   output reg soft_reset_pulse,
   output reg gating_enable,
   output wire [31:0] general_configuration
);

   // Gating states
   localparam ST_RUN = 2'b00;
   localparam ST_DELAY = 2'b01;
   localparam ST_GATED = 2'b10;

   reg [31:0] genconf_r;
   reg [31:0] genconf_nxt;
   reg [31:0] gate_delay_r;
   reg [31:0] gate_delay_nxt;
   reg [2:0] trigger_r;
   reg [2:0] trigger_nxt;
   reg reset_flag_r;
   reg reset_flag_nxt;
   reg [31:0] count_r;
   reg [31:0] count_nxt;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   wire rst_any_n;
   wire wake_sync;
   wire wr_genconf;
   wire wr_delay;
   wire wr_ctrl;
   wire wr_event_flag_register;
   wire key_hit;
   wire soft_reset;
   wire trigger_hit;
   wire gate_en_bit;
   wire [2:0] trig_field;
   wire [23:0] key_field;
   wire delay_zero;
   wire count_last;
   wire wake_req;
   wire [31:0] ctrl_word;
   wire [31:0] event_word;
   wire [31:0] status_word;
   reg [31:0] rdata_nxt;

   // Hardware pin and power-on reset combined into one async reset
   assign rst_any_n = reset_n & power_on_reset_n;

   // Wake pin is synchronised before any logic looks at it
   rcgu_sync #(.WIDTH(1)) u_wake_sync
   (
      .clk_sys(clk_sys),
      .reset_n(rst_any_n),
      .async_in(wake_input_pin),
      .sync_out(wake_sync)
   );

   // Write decode; register port stays live while the core clock is gated
   assign wr_genconf = reg_wr & (reg_addr == `RCGU_ADDR_GENCONF);
   assign wr_delay = reg_wr & (reg_addr == `RCGU_ADDR_GATE_DELAY);
   assign wr_ctrl = reg_wr & (reg_addr == `RCGU_ADDR_GATE_CTRL);
   assign wr_event_flag_register = reg_wr & (reg_addr == `RCGU_ADDR_EVENT_FLAG_REGISTER);

   // Fields of the shared control word and the gating enable bit
   assign trig_field = reg_wdata[`RCGU_TRIG_MSB:`RCGU_TRIG_LSB];
   assign key_field = reg_wdata[`RCGU_KEY_MSB:`RCGU_KEY_LSB];
   assign gate_en_bit = genconf_r[`RCGU_GENCONF_GATE_EN_BIT];

   // Software reset key, refused while freeze_condition
   assign key_hit = (key_field == `RCGU_SOFT_RESET_KEY);
   assign soft_reset = wr_ctrl & key_hit & ~freeze_condition;

   // Arming write, only honoured with gating enabled
   assign trigger_hit = wr_ctrl
      & (trig_field == `RCGU_TRIGGER_ARM)
      & gate_en_bit;

   // Delay counter end points
   assign delay_zero = (gate_delay_r == 32'h00000000);
   assign count_last = (count_r == 32'h00000001);

   // Wake request from the pin or from clearing the enable bit
   assign wake_req = wake_sync | ~gate_en_bit;

   // Register next values
   always @*
   begin
      genconf_nxt = genconf_r;
      gate_delay_nxt = gate_delay_r;
      trigger_nxt = trigger_r;
      if (wr_genconf)
         genconf_nxt = reg_wdata;
      if (wr_delay)
         gate_delay_nxt = reg_wdata;
      if (wr_ctrl)
         trigger_nxt = trig_field;
      if (soft_reset)
      begin
         genconf_nxt = `RCGU_GENCONF_RESET;
         gate_delay_nxt = `RCGU_GATE_DELAY_RESET;
         trigger_nxt = `RCGU_TRIGGER_RESET;
      end
   end

   // Reset flag is write-one-to-clear; a soft reset in the same cycle wins
   always @*
   begin
      reset_flag_nxt = reset_flag_r;
      if (wr_event_flag_register && reg_wdata[`RCGU_EVENT_FLAG_REGISTER_RESET_BIT])
         reset_flag_nxt = 1'b0;
      if (soft_reset)
         reset_flag_nxt = 1'b1;
   end

   // Gating state machine and delay counter
   always @*
   begin
      state_nxt = state_r;
      count_nxt = count_r;
      case (state_r)
         ST_RUN:
         begin
            if (trigger_hit)
            begin
               count_nxt = gate_delay_r;
               if (delay_zero)
                  state_nxt = ST_GATED;
               else
                  state_nxt = ST_DELAY;
            end
         end
         ST_DELAY:
         begin
            if (trigger_hit)
            begin
               // Re-arm reloads the counter; a zero delay gates at once
               count_nxt = gate_delay_r;
               if (delay_zero)
                  state_nxt = ST_GATED;
            end
            else
            begin
               count_nxt = count_r - 32'h00000001;
               if (count_last)
                  state_nxt = ST_GATED;
            end
            if (wake_req)
               state_nxt = ST_RUN;
         end
         ST_GATED:
         begin
            // Host wake path: re-arm with a long delay, then disable
            if (trigger_hit && !delay_zero)
            begin
               count_nxt = gate_delay_r;
               state_nxt = ST_DELAY;
            end
            if (wake_req)
               state_nxt = ST_RUN;
         end
         default:
         begin
            state_nxt = ST_RUN;
            count_nxt = 32'h00000000;
         end
      endcase
      if (soft_reset)
      begin
         state_nxt = ST_RUN;
         count_nxt = 32'h00000000;
      end
   end

   // Configuration registers; async reset from pin or power-on
   always @(posedge clk_sys or negedge rst_any_n)
   begin
      if (!rst_any_n)
      begin
         genconf_r <= `RCGU_GENCONF_RESET;
         gate_delay_r <= `RCGU_GATE_DELAY_RESET;
         trigger_r <= `RCGU_TRIGGER_RESET;
      end
      else
      begin
         genconf_r <= genconf_nxt;
         gate_delay_r <= gate_delay_nxt;
         trigger_r <= trigger_nxt;
      end
   end

   // Reset-occurred flag; every reset source sets it
   always @(posedge clk_sys or negedge rst_any_n)
   begin
      if (!rst_any_n)
         reset_flag_r <= 1'b1;
      else
         reset_flag_r <= reset_flag_nxt;
   end

   // Gating state and delay counter
   always @(posedge clk_sys or negedge rst_any_n)
   begin
      if (!rst_any_n)
      begin
         count_r <= 32'h00000000;
         state_r <= ST_RUN;
      end
      else
      begin
         count_r <= count_nxt;
         state_r <= state_nxt;
      end
   end

   // Registered control outputs
   always @(posedge clk_sys or negedge rst_any_n)
   begin
      if (!rst_any_n)
      begin
         soft_reset_pulse <= 1'b0;
         core_clock_enable <= 1'b1;
         gating_enable <= 1'b0;
      end
      else
      begin
         soft_reset_pulse <= soft_reset;
         // Enable for the gate on the distributed copy of clk_sys
         core_clock_enable <= (state_nxt != ST_GATED);
         gating_enable <= genconf_nxt[`RCGU_GENCONF_GATE_EN_BIT];
      end
   end

   assign general_configuration = genconf_r;

   // Read-back words; key field and unused bits read zero
   assign ctrl_word = {29'h00000000, trigger_r};
   assign event_word = {reset_flag_r, 31'h00000000};
   assign status_word = {30'h00000000, state_r};

   // Read multiplexer; unmapped addresses read zero
   always @*
   begin
      rdata_nxt = 32'h00000000;
      case (reg_addr)
         `RCGU_ADDR_GENCONF: rdata_nxt = genconf_r;
         `RCGU_ADDR_GATE_DELAY: rdata_nxt = gate_delay_r;
         `RCGU_ADDR_GATE_CTRL: rdata_nxt = ctrl_word;
         `RCGU_ADDR_EVENT_FLAG_REGISTER: rdata_nxt = event_word;
         `RCGU_ADDR_STATUS: rdata_nxt = status_word;
         default: rdata_nxt = 32'h00000000;
      endcase
   end

   // Read port, answer one cycle after the strobe; stays live while gated
   always @(posedge clk_sys or negedge rst_any_n)
   begin
      if (!rst_any_n)
      begin
         reg_rdata <= 32'h00000000;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= rdata_nxt;
      end
   end

endmodule // rcgu_top

// ### verif/rcgu_board.sv
// Board model: reset sources and wake-up pin
`timescale 1ns/1ps
module rcgu_board
(
   // Clock
   input wire clk_sys,
   // Reset and wake sources
   output logic reset_n,
   output logic power_on_reset_n,
   output logic wake_input_pin
);
   // Power-up with both resets low for two cycles
   initial
   begin
      reset_n = 1'b0;
      power_on_reset_n = 1'b0;
      wake_input_pin = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      power_on_reset_n = 1'b1;
   end
   // Wake level, high means wake
   task automatic wake(input bit lvl);
      @(posedge clk_sys);
      #1 wake_input_pin = lvl;
   endtask
   // One reset source low for two cycles
   task automatic pulse(input bit por);
      @(posedge clk_sys);
      #1;
      if (por) power_on_reset_n = 1'b0;
      else reset_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      power_on_reset_n = 1'b1;
   endtask
endmodule // rcgu_board

// ### verif/rcgu_top_chk.sv
// Port checker for the reset and clock gating unit
`timescale 1ns/1ps
module rcgu_top_chk
(
   // Clock and resets
   input wire clk_sys,
   input wire reset_n,
   input wire power_on_reset_n,
   // Inputs
   input wire wake_input_pin,
   input wire freeze_condition,
   input wire [6:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   // Outputs
   input wire [31:0] reg_rdata,
   input wire reg_rvalid,
   input wire core_clock_enable,
   input wire soft_reset_pulse,
   input wire gating_enable,
   input wire [31:0] general_configuration
);
   // Key write decode
   wire key_wr = reg_wr && reg_addr == 7'h4f && reg_wdata[31:8] == 24'h525354;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!(reset_n && power_on_reset_n));
   a_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   a_unmapped_zero: assert property (reg_rd && reg_addr == 7'h7f |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_key_reads_zero: assert property (reg_rd && reg_addr == 7'h4f |=> reg_rdata[31:8] == 24'h0)
      else $error("key field not zero");
   a_key_accepted: assert property (key_wr && !freeze_condition |=> soft_reset_pulse ##1 !soft_reset_pulse)
      else $error("key write not taken");
   a_freeze_blocks: assert property (key_wr && freeze_condition |=> !soft_reset_pulse)
      else $error("key taken while freeze_condition");
   a_soft_defaults: assert property (soft_reset_pulse |-> general_configuration == 32'h00006020)
      else $error("config not default");
   a_soft_runs: assert property (soft_reset_pulse |-> core_clock_enable)
      else $error("clock gated after soft reset");
   a_gate_needs_en: assert property ($fell(core_clock_enable) |-> gating_enable)
      else $error("gated without enable");
   a_wake_ends: assert property ($rose(wake_input_pin) ##1 wake_input_pin [*2] |=> core_clock_enable)
      else $error("wake did not ungate");
endmodule // rcgu_top_chk
bind rcgu_top rcgu_top_chk rcgu_top_chk_inst (.clk_sys(clk_sys), .reset_n(reset_n),
   .power_on_reset_n(power_on_reset_n), .wake_input_pin(wake_input_pin),
   .freeze_condition(freeze_condition), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .core_clock_enable(core_clock_enable), .soft_reset_pulse(soft_reset_pulse),
   .gating_enable(gating_enable), .general_configuration(general_configuration));

// ### verif/testbench.sv
// Self-checking testbench for the reset and clock gating unit
`timescale 1ns/1ps
module testbench;
   logic clk_sys, reset_n, power_on_reset_n, wake_input_pin, freeze_condition;
   logic [6:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, general_configuration, rd_val;
   logic reg_wr, reg_rd, reg_rvalid, core_clock_enable, soft_reset_pulse, gating_enable;
   int bad_count, samples_checked;
   // Rows of address and reset value
   logic [38:0] rows [0:4] = '{{7'h00, 32'h00006020}, {7'h14, 32'h0}, {7'h4f, 32'h0},
      {7'h0e, 32'h80000000}, {7'h7f, 32'h0}};
   rcgu_board rcgu_board_inst (.clk_sys(clk_sys), .reset_n(reset_n),
      .power_on_reset_n(power_on_reset_n), .wake_input_pin(wake_input_pin));
   rcgu_top rcgu_top_inst (.clk_sys(clk_sys), .reset_n(reset_n),
      .power_on_reset_n(power_on_reset_n), .wake_input_pin(wake_input_pin),
      .freeze_condition(freeze_condition), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .core_clock_enable(core_clock_enable), .soft_reset_pulse(soft_reset_pulse),
      .gating_enable(gating_enable), .general_configuration(general_configuration));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk_sys);
      #1 reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [6:0] a);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk_sys);
      #1 reg_rd = 1'b0;
      rd_val = reg_rdata;
      check(reg_rvalid, 1'b1);
   endtask
   // Trigger gating after a delay of d cycles
   task automatic gate(input int d);
      wr(7'h14, d);
      wr(7'h4f, 32'h7);
      repeat (d)
      begin
         check(core_clock_enable, 1'b1);
         @(posedge clk_sys);
         #1;
      end
      check(core_clock_enable, 1'b0);
   endtask
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Watchdog
   initial
   begin
      #20000;
      bad_count++;
      end_sim;
   end
   initial
   begin
      {freeze_condition, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      wait (reset_n && power_on_reset_n);
      for (int i = 0; i < 5; i++)
      begin
         rd(rows[i][38:32]);
         check(rd_val, rows[i][31:0]);
      end
      wr(7'h4f, 32'h7);
      repeat (3) @(posedge clk_sys);
      #1 check(core_clock_enable, 1'b1);
      wr(7'h00, 32'h00026020);
      check(gating_enable, 1'b1);
      gate(2);
      rcgu_board_inst.wake(1'b1);
      repeat (3) @(posedge clk_sys);
      #1 check(core_clock_enable, 1'b1);
      rcgu_board_inst.wake(1'b0);
      gate(0);
      rd(7'h00);
      check(rd_val, 32'h00026020);
      wr(7'h14, 32'hffffffff);
      wr(7'h4f, 32'h0);
      wr(7'h4f, 32'h7);
      check(core_clock_enable, 1'b1);
      rd(7'h4e);
      check(rd_val, 32'h1);
      wr(7'h00, 32'h00006020);
      check(core_clock_enable, 1'b1);
      rd(7'h4e);
      check(rd_val, 32'h0);
      wr(7'h00, 32'h00026020);
      wr(7'h14, 32'h20);
      wr(7'h4f, 32'h7);
      wr(7'h14, 32'h0);
      wr(7'h4f, 32'h7);
      check(core_clock_enable, 1'b0);
      wr(7'h0e, 32'h80000000);
      freeze_condition = 1'b1;
      wr(7'h4f, 32'h52535400);
      check(soft_reset_pulse, 1'b0);
      rd(7'h0e);
      check(rd_val[31], 1'b0);
      freeze_condition = 1'b0;
      wr(7'h4f, 32'h52535400);
      check(soft_reset_pulse, 1'b1);
      check(general_configuration, 32'h00006020);
      check(core_clock_enable, 1'b1);
      check(gating_enable, 1'b0);
      rd(7'h0e);
      check(rd_val[31], 1'b1);
      for (int p = 0; p < 2; p++)
      begin
         wr(7'h00, 32'h00026020);
         wr(7'h0e, 32'h80000000);
         rcgu_board_inst.pulse(p[0]);
         rd(7'h00);
         check(rd_val, 32'h00006020);
         rd(7'h0e);
         check(rd_val[31], 1'b1);
      end
      end_sim;
   end
endmodule // testbench
